// *** rtl/uart_cfg_pkg.sv ***
// Shared constants for the configurable UART transmit block
package uart_cfg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_DIV_LOW  = 3'h0;
  localparam logic [2:0] IDX_TX_HOLD  = 3'h0;
  localparam logic [2:0] IDX_DIV_HIGH = 3'h1;
  localparam logic [2:0] IDX_FIFO_CTL = 3'h2;
  localparam logic [2:0] IDX_ENH_FEAT = 3'h2;
  localparam logic [2:0] IDX_LINE_CFG = 3'h3;
  localparam logic [2:0] IDX_STATUS   = 3'h5;
  localparam logic [2:0] IDX_DIV_FRAC = 3'h7;
  // Line configuration codes and fields
  localparam logic [7:0] LINE_ENH_KEY  = 8'hbf;
  localparam int         LINE_DIV_BIT  = 7;
  // Enhanced feature and fifo control fields
  localparam int         ENH_EN_BIT    = 4;
  localparam int         FIFO_EN_BIT   = 0;
  localparam int         TX_CLR_BIT    = 2;
  // Baud generation and word length
  localparam int         OVERSAMPLE    = 16;
  localparam int         FRAC_BITS     = 6;
  localparam logic [21:0] FRAC_STEP    = 22'h000040;
  localparam int         MIN_WORD_BITS = 5;
  // Values after reset
  localparam logic [7:0] LINE_RESET    = 8'h03;
  localparam logic [7:0] DIV_LOW_RESET = 8'h01;
  localparam logic [7:0] ZERO_RESET    = 8'h00;
endpackage

// *** rtl/uart_baud_fifo_setup.sv ***
// UART with paged registers, fractional baud divisor, transmit fifo and shifter
// Notes on behaviour
// RULE1: Host programs divisor, then line format, then resets fifos before sending.
// RULE2: Each bit lasts sixteen baud ticks; tick rate is clock over divisor.
// RULE3: Fraction register adds divisor steps of one sixty-fourth when enhanced.
// RULE4: Line config value 0xbf opens the enhanced feature register page.
// RULE5: On that page index 2 is enhanced feature; bit 4 enables fraction.
// RULE6: Line config 0x93 exposes divisor page, eight bits, no parity, one stop.
// RULE7: Divisor page: low byte index 0, high byte 1, fraction 7.
// RULE8: Line config 0x13 restores normal map keeping eight-bit format.
// RULE9: Fifo control 0x06 clears fifos; 0x01 enables fifo operation.
// RULE10: Holding write queues the byte; the shifter then sends it.
// RULE11: Frame is low start, data lsb first, high stop, then next byte.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module uart_baud_fifo_setup #(
  parameter int DEPTH = 128
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [4:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Serial line
  output logic             o_tx
);
  localparam int AW = $clog2(DEPTH);

  // Page decode shared by read and write paths
  function automatic logic [1:0] page_of(input logic [7:0] line_config);
    if (line_config == uart_cfg_pkg::LINE_ENH_KEY) page_of = 2'h2;
    else if (line_config[uart_cfg_pkg::LINE_DIV_BIT]) page_of = 2'h1;
    else page_of = 2'h0;
  endfunction

  logic [7:0]  line_cfg_q;
  logic [7:0]  enh_feat_q;
  logic [7:0]  div_low_q;
  logic [7:0]  div_high_q;
  logic [7:0]  div_frac_q;
  logic        fifo_en_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [7:0]  mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic [21:0] acc_q;
  logic        active_q;
  logic [3:0]  slot_q;
  logic [3:0]  os_q;
  logic [7:0]  sh_q;
  logic        tx_q;

  // Bus decode
  wire         req      = i_wb_cyc & i_wb_stb;
  wire         wr       = req & ack_q & i_wb_we & i_wb_sel[0];
  wire [2:0]   idx      = i_wb_adr[4:2];
  wire [7:0]   wdat     = i_wb_dat[7:0];
  wire [1:0]   page     = page_of(line_cfg_q);
  wire         pg_norm  = (page == 2'h0);
  wire         pg_div   = (page == 2'h1);
  wire         pg_enh   = (page == 2'h2);
  wire         wr_line  = wr & (idx == uart_cfg_pkg::IDX_LINE_CFG);
  wire         wr_enh   = wr & pg_enh & (idx == uart_cfg_pkg::IDX_ENH_FEAT);
  wire         wr_low   = wr & pg_div & (idx == uart_cfg_pkg::IDX_DIV_LOW);
  wire         wr_high  = wr & pg_div & (idx == uart_cfg_pkg::IDX_DIV_HIGH);
  wire         wr_frac  = wr & pg_div & (idx == uart_cfg_pkg::IDX_DIV_FRAC);
  wire         wr_fifo  = wr & pg_norm & (idx == uart_cfg_pkg::IDX_FIFO_CTL);
  wire         wr_hold  = wr & pg_norm & (idx == uart_cfg_pkg::IDX_TX_HOLD);

  // Fifo status and control
  wire         empty    = (cnt_q == '0);
  wire         full     = fifo_en_q ? (cnt_q == (AW+1)'(DEPTH)) : !empty;
  wire         tx_clr   = wr_fifo & wdat[uart_cfg_pkg::TX_CLR_BIT];
  wire         push     = wr_hold & !full & !tx_clr;
  wire         pop      = !active_q & !empty & !tx_clr;

  // Baud tick: accumulate in 1/64 clock units against the divisor
  wire [5:0]   frac     = enh_feat_q[uart_cfg_pkg::ENH_EN_BIT] ? div_frac_q[5:0] : 6'h00;
  wire [21:0]  dfull    = {div_high_q, div_low_q, frac};
  wire [21:0]  acc_n    = acc_q + uart_cfg_pkg::FRAC_STEP;
  wire         tick     = (dfull != '0) & (acc_n >= dfull);

  // Shifter frame positions
  wire [3:0]   nbits    = 4'(uart_cfg_pkg::MIN_WORD_BITS) + {2'h0, line_cfg_q[1:0]};
  wire [3:0]   last     = nbits + 4'h1;
  wire         bit_end  = active_q & tick & (os_q == 4'(uart_cfg_pkg::OVERSAMPLE - 1));
  wire         tx_d     = !active_q ? 1'b1 : (slot_q == 4'h0) ? 1'b0 :
                          (slot_q == last) ? 1'b1 : sh_q[0];

  // Read data selection
  wire [7:0]   status   = {5'h00, full, empty & !active_q, empty};
  wire [7:0]   rd_val   =
    (idx == uart_cfg_pkg::IDX_LINE_CFG)          ? line_cfg_q :
    (pg_enh & idx == uart_cfg_pkg::IDX_ENH_FEAT) ? enh_feat_q :
    (pg_div & idx == uart_cfg_pkg::IDX_DIV_LOW)  ? div_low_q  :
    (pg_div & idx == uart_cfg_pkg::IDX_DIV_HIGH) ? div_high_q :
    (pg_div & idx == uart_cfg_pkg::IDX_DIV_FRAC) ? div_frac_q :
    (pg_norm & idx == uart_cfg_pkg::IDX_STATUS)  ? status     : 8'h00;

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;
  assign o_tx     = tx_q;

  // Bus acknowledge and read data
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= req & !ack_q;
      rdat_q <= (req & !ack_q & !i_wb_we) ? {24'h0, rd_val} : 32'h0;
    end
  end

  // Configuration registers
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      line_cfg_q <= uart_cfg_pkg::LINE_RESET;
      enh_feat_q <= uart_cfg_pkg::ZERO_RESET;
      div_low_q  <= uart_cfg_pkg::DIV_LOW_RESET;
      div_high_q <= uart_cfg_pkg::ZERO_RESET;
      div_frac_q <= uart_cfg_pkg::ZERO_RESET;
      fifo_en_q  <= 1'b0;
    end else begin
      if (wr_line) line_cfg_q <= wdat;  // see RULE4 RULE6 RULE8
      if (wr_enh)  enh_feat_q <= wdat;  // see RULE5
      if (wr_low)  div_low_q  <= wdat;  // see RULE7
      if (wr_high) div_high_q <= wdat;  // see RULE7
      if (wr_frac) div_frac_q <= wdat;  // see RULE7 RULE3
      if (wr_fifo) fifo_en_q  <= wdat[uart_cfg_pkg::FIFO_EN_BIT];  // see RULE9
    end
  end

  // Baud accumulator
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) acc_q <= '0;
    else if (dfull == '0) acc_q <= '0;
    else acc_q <= tick ? acc_n - dfull : acc_n;  // see RULE2 RULE3
  end

  // Fifo storage; without fifo mode it acts as a single holding slot
  always_ff @(posedge i_clock) begin
    if (push) mem[wp_q] <= wdat;  // see RULE10
  end

  // Fifo pointers; clearing wins over queueing in the same write
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (tx_clr) begin  // see RULE9
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop)  rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Transmit shifter
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      active_q <= 1'b0;
      slot_q   <= 4'h0;
      os_q     <= 4'h0;
      sh_q     <= 8'h00;
      tx_q     <= 1'b1;
    end else begin
      tx_q <= tx_d;  // see RULE11
      if (pop) begin  // see RULE10
        active_q <= 1'b1;
        slot_q   <= 4'h0;
        os_q     <= 4'h0;
        sh_q     <= mem[rp_q];
      end else if (active_q & tick) begin
        os_q <= os_q + 4'h1;  // see RULE2
        if (bit_end) begin
          if (slot_q == last) active_q <= 1'b0;  // see RULE11
          else slot_q <= slot_q + 4'h1;
          if (slot_q != 4'h0) sh_q <= {1'b0, sh_q[7:1]};  // see RULE11
        end
      end
    end
  end

  // Checks
  sequence s_start;
    active_q && slot_q == 4'h0;
  endsequence
  sequence s_stop;
    active_q && slot_q == last;
  endsequence

  property p_enh_open;
    @(posedge i_clock) disable iff (!i_resetn)
    wr_line && wdat == 8'hbf |=> pg_enh && !pg_div;
  endproperty
  a_enh_open: assert property (p_enh_open) else $error("enhanced page not opened");  // see RULE4

  property p_enh_write;
    @(posedge i_clock) disable iff (!i_resetn)
    pg_enh && wr && idx == 3'h2 |=> enh_feat_q == $past(wdat) && !fifo_en_q == !$past(fifo_en_q);
  endproperty
  a_enh_write: assert property (p_enh_write) else $error("enhanced write misrouted");  // see RULE5

  property p_div_open;
    @(posedge i_clock) disable iff (!i_resetn)
    wr_line && wdat == 8'h93 |=> pg_div && nbits == 4'h8;
  endproperty
  a_div_open: assert property (p_div_open) else $error("divisor page not opened");  // see RULE6

  property p_div_map;
    @(posedge i_clock) disable iff (!i_resetn)
    pg_div && wr && idx == 3'h7 |=> div_frac_q == $past(wdat) && $stable(div_low_q);
  endproperty
  a_div_map: assert property (p_div_map) else $error("fraction write misrouted");  // see RULE7

  property p_normal;
    @(posedge i_clock) disable iff (!i_resetn)
    wr_line && wdat == 8'h13 |=> pg_norm && nbits == 4'h8;
  endproperty
  a_normal: assert property (p_normal) else $error("normal map not restored");  // see RULE8

  property p_fifo_clear;
    @(posedge i_clock) disable iff (!i_resetn)
    wr_fifo && wdat == 8'h06 |=> empty ##1 (!active_q || $past(active_q));
  endproperty
  a_fifo_clear: assert property (p_fifo_clear) else $error("fifo not cleared");  // see RULE9

  property p_queue;
    @(posedge i_clock) disable iff (!i_resetn)
    fifo_en_q && wr_hold && !full && !active_q |=> ##[0:1] active_q;
  endproperty
  a_queue: assert property (p_queue) else $error("queued byte not sent");  // see RULE10

  property p_frame;
    @(posedge i_clock) disable iff (!i_resetn)
    $rose(active_q) |=> s_start ##0 !o_tx;
  endproperty
  a_frame: assert property (p_frame) else $error("start bit not low");  // see RULE11

  property p_stop;
    @(posedge i_clock) disable iff (!i_resetn)
    s_stop |=> o_tx;
  endproperty
  a_stop: assert property (p_stop) else $error("stop bit not high");  // see RULE11

  property p_tick;
    @(posedge i_clock) disable iff (!i_resetn)
    tick && dfull > 22'h80 |=> !tick;
  endproperty
  a_tick: assert property (p_tick) else $error("baud tick too fast");  // see RULE2 RULE3

  property p_enh_hidden;
    @(posedge i_clock) disable iff (!i_resetn)
    pg_norm && wr && idx == 3'h2 |=> $stable(enh_feat_q);
  endproperty
  a_enh_hidden: assert property (p_enh_hidden) else $error("enhanced written off page");  // see RULE5

  property p_div_low;
    @(posedge i_clock) disable iff (!i_resetn)
    pg_div && wr && idx == 3'h0 |=> div_low_q == $past(wdat) && $stable(div_high_q);
  endproperty
  a_div_low: assert property (p_div_low) else $error("divisor low write misrouted");  // see RULE7

  property p_div_high;
    @(posedge i_clock) disable iff (!i_resetn)
    pg_div && wr && idx == 3'h1 |=> div_high_q == $past(wdat) && $stable(div_low_q);
  endproperty
  a_div_high: assert property (p_div_high) else $error("divisor high write misrouted");  // see RULE7

  property p_fifo_on;
    @(posedge i_clock) disable iff (!i_resetn)
    wr_fifo && wdat == 8'h01 |=> fifo_en_q;
  endproperty
  a_fifo_on: assert property (p_fifo_on) else $error("fifo mode not enabled");  // see RULE9

  property p_push_count;
    @(posedge i_clock) disable iff (!i_resetn)
    push && !pop |=> cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_push_count: assert property (p_push_count) else $error("queued byte not counted");  // see RULE10

  property p_data_lsb;
    @(posedge i_clock) disable iff (!i_resetn)
    active_q && slot_q != 4'h0 && slot_q != last |=> o_tx == $past(sh_q[0]);
  endproperty
  a_data_lsb: assert property (p_data_lsb) else $error("data bit order wrong");  // see RULE11

  property p_remainder;
    @(posedge i_clock) disable iff (!i_resetn)
    tick && acc_q < dfull && dfull >= 22'h40 |=> acc_q < $past(dfull);
  endproperty
  a_remainder: assert property (p_remainder) else $error("baud remainder overrun");  // see RULE2 RULE3
endmodule

// *** test/uart_line_partner.sv ***
// Remote receiver model that decodes the serial line
`timescale 1ns/1ps
module uart_line_partner #(
  parameter int BIT_CLKS = 40
) (
  // Clock and line
  input  wire logic       i_clock,
  input  wire logic       i_line,
  // Decoded result
  output logic      [7:0] o_byte,
  output int              o_count,
  output int              o_errs
);
  logic [7:0] bits;
  logic       ok;
  // Sample mid-bit, low start then lsb first then high stop
  initial begin
    o_byte = 8'h00;
    o_count = 0;
    o_errs = 0;
    forever begin
      @(negedge i_line);
      repeat (BIT_CLKS / 2) @(posedge i_clock);
      ok = (i_line === 1'b0);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge i_clock);
        bits[i] = i_line;
      end
      repeat (BIT_CLKS) @(posedge i_clock);
      ok = ok && (i_line === 1'b1);
      o_byte = bits;
      if (!ok) o_errs++;
      o_count++;
    end
  end
endmodule

// *** test/uart_baud_fifo_setup_tb_top.sv ***
// Testbench for register pages, fractional baud and fifo transmit
`timescale 1ns/1ps
module uart_baud_fifo_setup_tb_top;
  logic        i_clock = 1'b0;
  logic        i_resetn = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [4:0]  wb_adr = 5'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [3:0]  sel_v = 4'h1;
  logic [31:0] wb_wdat = 32'h00000000;
  logic [31:0] wb_rdat;
  logic [31:0] rdat;
  logic        wb_ack;
  logic        tx_line;
  logic [7:0]  rx_byte;
  logic [7:0]  got_q[$];
  int          rx_count, rx_errs, cycles = 0, failures = 0, n_checks = 0;
  // Clock and cycle ceiling
  always #2.5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      end_of_test();
    end
  end
  // Collect each decoded byte once the partner has counted it
  always @(posedge i_clock) begin
    if (rx_count > got_q.size()) got_q.push_back(rx_byte);
  end
  uart_baud_fifo_setup #(.DEPTH(4)) u_uart_baud_fifo_setup (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
    .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat),
    .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .o_tx(tx_line));
  // Divisor 2.5 clocks gives a 40 clock bit
  uart_line_partner #(.BIT_CLKS(40)) u_uart_line_partner (
    .i_clock(i_clock), .i_line(tx_line), .o_byte(rx_byte), .o_count(rx_count),
    .o_errs(rx_errs));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [2:0] idx, input logic [7:0] d);
    @(posedge i_clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_sel <= sel_v;
    wb_adr <= {idx, 2'b00};
    wb_wdat <= {24'h000000, d};
    do @(posedge i_clock); while (wb_ack !== 1'b1);
    rdat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      wb(1'b0, uart_cfg_pkg::IDX_STATUS, 8'h00);
      n++;
    end while (rdat[1] !== 1'b1 && n < 2000);
    chk("tx_idle", 32'h00000001, {31'h0, rdat[1]});
  endtask
  task automatic t_reset;
    wb(1'b0, uart_cfg_pkg::IDX_LINE_CFG, 8'h00);
    chk("line_config", {24'h000000, uart_cfg_pkg::LINE_RESET}, rdat);
    sel_v = 4'h0;
    wb(1'b1, uart_cfg_pkg::IDX_LINE_CFG, 8'h80);
    sel_v = 4'h1;
    wb(1'b0, uart_cfg_pkg::IDX_LINE_CFG, 8'h00);
    chk("line_config_nosel", {24'h000000, uart_cfg_pkg::LINE_RESET}, rdat);
    wb(1'b0, 3'h4, 8'h00);
    chk("unmapped", 32'h00000000, rdat);
    $display("test reset done");
  endtask
  task automatic t_pages;
    wb(1'b1, uart_cfg_pkg::IDX_LINE_CFG, 8'hbf);
    wb(1'b1, uart_cfg_pkg::IDX_ENH_FEAT, 8'h10);
    wb(1'b0, uart_cfg_pkg::IDX_ENH_FEAT, 8'h00);
    chk("enhanced", 32'h00000010, rdat);
    wb(1'b1, uart_cfg_pkg::IDX_LINE_CFG, 8'h93);
    wb(1'b1, uart_cfg_pkg::IDX_DIV_HIGH, 8'h00);
    wb(1'b1, uart_cfg_pkg::IDX_DIV_LOW, 8'h02);
    wb(1'b1, uart_cfg_pkg::IDX_DIV_FRAC, 8'h20);
    wb(0, uart_cfg_pkg::IDX_DIV_LOW, 0);
    chk("div_low", 32'h00000002, rdat);
    wb(0, uart_cfg_pkg::IDX_DIV_FRAC, 0);
    chk("div_frac", 32'h00000020, rdat);
    wb(1'b1, uart_cfg_pkg::IDX_LINE_CFG, 8'h13);
    wb(1'b0, uart_cfg_pkg::IDX_LINE_CFG, 8'h00);
    chk("line_config", 32'h00000013, rdat);
    $display("test pages done");
  endtask
  task automatic t_send;
    wb(1'b1, uart_cfg_pkg::IDX_FIFO_CTL, 8'h06);
    wb(1'b1, uart_cfg_pkg::IDX_FIFO_CTL, 8'h01);
    wb(1'b1, uart_cfg_pkg::IDX_TX_HOLD, 8'haa);
    wb(1'b1, uart_cfg_pkg::IDX_TX_HOLD, 8'h35);
    wait_idle();
    chk("rx_count", 32'd2, rx_count);
    chk("byte0", 32'h000000aa, {24'h000000, got_q[0]});
    chk("byte1", 32'h00000035, {24'h000000, got_q[1]});
    $display("test send done");
  endtask
  task automatic t_clear;
    wb(1'b1, uart_cfg_pkg::IDX_TX_HOLD, 8'h11);
    wb(1'b1, uart_cfg_pkg::IDX_TX_HOLD, 8'h22);
    wb(1'b1, uart_cfg_pkg::IDX_TX_HOLD, 8'h33);
    wb(1'b1, uart_cfg_pkg::IDX_FIFO_CTL, 8'h06);
    wait_idle();
    chk("rx_count", 32'd3, rx_count);
    chk("byte2", 32'h00000011, {24'h000000, got_q[2]});
    chk("frame_errs", 32'd0, rx_errs);
    wb(1'b1, uart_cfg_pkg::IDX_FIFO_CTL, 8'h01);
    $display("test clear done");
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge i_clock);
    i_resetn <= 1'b1;
    t_reset();
    t_pages();
    t_send();
    t_clear();
    end_of_test();
  end
endmodule
